// ---- rtl/cms_pkg.sv ----
// Constants and types shared by the sync scheduler files
// Summary of operation
// - Node address 1..127 sets heartbeat identifier.
// - Sync period equals task period times ratio.
// - Ratio above one spans several task cycles.
// - Output PDOs wait percent of sync period.
// - Input update at percent of host cycle.
// - Update leaves copy duration before next cycle.
// - Host bus reset sends network reset broadcast when no walk runs.
// - Scan in config mode reads PDO, identity.
// - Verify in config mode compares identity objects.
// - New bit rate checked against every slave.
package cms_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int RESP_TIMEOUT_NS = 1000000;
  localparam int RESP_TIMEOUT_CYC = RESP_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam logic [6:0] NODE_MIN = 7'h01;
  localparam logic [6:0] NODE_MAX = 7'h7F;
  localparam logic [6:0] NODE_BROADCAST = 7'h00;
  localparam logic [10:0] HB_COB_BASE = 11'h700;
  localparam logic [7:0] PCT_FULL = 8'h64;
  localparam logic [7:0] RATIO_MIN = 8'h01;
  localparam int PIN_W = 5;
  localparam int PIN_TICK = 4;

  typedef enum logic [1:0] {
    CMS_OP_NMT_RESET,
    CMS_OP_PDO_CFG,
    CMS_OP_IDENTITY,
    CMS_OP_BITRATE
  } cms_op_t;

  typedef enum logic [1:0] {
    CMS_MODE_SCAN,
    CMS_MODE_VERIFY,
    CMS_MODE_BITRATE
  } cms_mode_t;

  typedef enum logic [1:0] {
    CMS_ST_IDLE,
    CMS_ST_ISSUE,
    CMS_ST_WAIT,
    CMS_ST_NEXT
  } cms_state_t;

  typedef struct packed {
    logic valid;
    cms_op_t op;
    logic [6:0] node;
  } cms_req_t;

  typedef struct packed {
    logic valid;
    logic ok;
  } cms_resp_t;

  typedef struct packed {
    logic bus_reset;
    logic scan;
    logic verify;
    logic bitrate_check;
  } cms_cmd_t;
endpackage

// ---- rtl/cms_pct_timer.sv ----
// Percent-of-period one-shot timer
`timescale 1ns/1ps
module cms_pct_timer import cms_pkg::*; #(
  parameter int CW = 24
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [CW-1:0] period,
  input wire logic [7:0] pct,
  input wire logic [CW-1:0] limit,
  output logic running,
  output logic fire
);
  logic running_ff;
  logic fire_ff;
  logic [CW-1:0] elapsed_ff;
  logic [CW+7:0] scaled_el;
  logic [CW+7:0] scaled_tg;
  logic hit;

  // Multiply instead of divide so no rounding error builds up
  assign scaled_el = (CW+8)'(elapsed_ff) * (CW+8)'(PCT_FULL);
  assign scaled_tg = (CW+8)'(period) * (CW+8)'(pct);
  assign hit = (scaled_el >= scaled_tg) || (elapsed_ff >= limit);
  assign running = running_ff;
  assign fire = fire_ff;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      running_ff <= 1'b0;
      elapsed_ff <= '0;
      fire_ff <= 1'b0;
    end else if (start) begin
      running_ff <= 1'b1;
      elapsed_ff <= '0;
      fire_ff <= 1'b0;
    end else if (running_ff && hit) begin
      running_ff <= 1'b0;
      fire_ff <= 1'b1;
    end else begin
      fire_ff <= 1'b0;
      if (running_ff) begin
        elapsed_ff <= elapsed_ff + 1'b1;
      end
    end
  end
endmodule

// ---- rtl/cms_sched.sv ----
// Sync, delay, input update and network walk scheduler
`timescale 1ns/1ps
module cms_sched import cms_pkg::*; #(
  parameter int CW = 24,
  parameter int RESP_TIMEOUT = RESP_TIMEOUT_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic task_tick_pin,
  input wire cms_cmd_t cmd_pin,
  input wire logic config_mode,
  input wire logic [6:0] own_node_address,
  input wire logic [7:0] sync_ratio,
  input wire logic [7:0] output_pdo_delay_percent,
  input wire logic [7:0] input_shift_percent,
  input wire logic [CW-1:0] input_copy_duration,
  input wire cms_resp_t resp,
  output logic sync_tx,
  output logic pdo_tx,
  output logic input_update,
  output logic [10:0] heartbeat_cob_id,
  output logic node_addr_valid,
  output logic [CW-1:0] task_period,
  output logic [CW-1:0] sync_period,
  output cms_req_t req,
  output logic busy,
  output logic [6:0] nodes_found,
  output logic mismatch,
  output logic bitrate_fail
);
  localparam int TW = $clog2(RESP_TIMEOUT + 1);
  localparam logic [TW-1:0] TIMEOUT_LAST = TW'(RESP_TIMEOUT - 1);

  logic [PIN_W-1:0] pin_s1_ff;
  logic [PIN_W-1:0] pin_s2_ff;
  logic [PIN_W-1:0] pin_s3_ff;
  logic [PIN_W-1:0] pin_lvl_ff;
  logic [PIN_W-1:0] pin_evt;
  logic tick;
  cms_cmd_t cmd_evt;
  logic [CW-1:0] cyc_cnt_ff;
  logic [CW-1:0] task_period_ff;
  logic [CW-1:0] sync_period_ff;
  logic [CW+7:0] sync_prod;
  logic [7:0] ratio_eff;
  logic [7:0] task_idx_ff;
  logic sync_tx_ff;
  logic [CW-1:0] in_limit;
  logic pdo_running;
  logic in_running;
  logic [10:0] hb_cob_ff;
  logic addr_ok_ff;
  cms_state_t state_ff;
  cms_mode_t mode_ff;
  logic phase_ff;
  logic [6:0] node_ff;
  logic [TW-1:0] wait_cnt_ff;
  cms_req_t req_ff;
  logic busy_ff;
  logic [6:0] found_ff;
  logic mismatch_ff;
  logic bitrate_fail_ff;
  logic resp_done;
  logic resp_ok;

  // Three stages; an edge counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_s3_ff <= '0;
    end else begin
      pin_s1_ff <= {task_tick_pin, cmd_pin};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_lvl_ff <= '0;
    end else begin
      pin_lvl_ff <= (pin_s2_ff & ~(pin_s2_ff ^ pin_s3_ff))
                  | (pin_lvl_ff & (pin_s2_ff ^ pin_s3_ff));
    end
  end

  assign pin_evt = pin_s2_ff & pin_s3_ff & ~pin_lvl_ff;
  assign tick = pin_evt[PIN_TICK];
  assign cmd_evt = cms_cmd_t'(pin_evt[PIN_TICK-1:0]);

  // Heartbeat identifier follows the node address
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hb_cob_ff <= HB_COB_BASE;
      addr_ok_ff <= 1'b0;
    end else begin
      hb_cob_ff <= HB_COB_BASE | {4'h0, own_node_address};
      addr_ok_ff <= (own_node_address >= NODE_MIN);
    end
  end

  // Task period measured between ticks; the counter saturates, but the period then wraps to zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cyc_cnt_ff <= '0;
      task_period_ff <= '0;
    end else if (tick) begin
      cyc_cnt_ff <= '0;
      task_period_ff <= cyc_cnt_ff + 1'b1;
    end else if (cyc_cnt_ff != '1) begin
      cyc_cnt_ff <= cyc_cnt_ff + 1'b1;
    end
  end

  // Ratio of zero is treated as one
  assign ratio_eff = (sync_ratio < RATIO_MIN) ? RATIO_MIN : sync_ratio;
  assign sync_prod = (CW+8)'(task_period_ff) * (CW+8)'(ratio_eff);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync_period_ff <= '0;
    end else if (sync_prod[CW+7:CW] != '0) begin
      sync_period_ff <= '1;
    end else begin
      sync_period_ff <= sync_prod[CW-1:0];
    end
  end

  // Task cycles counted modulo the ratio; sync on wrap
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      task_idx_ff <= '0;
      sync_tx_ff <= 1'b0;
    end else if (tick && (task_idx_ff >= ratio_eff - RATIO_MIN)) begin
      task_idx_ff <= '0;
      sync_tx_ff <= 1'b1;
    end else begin
      sync_tx_ff <= 1'b0;
      if (tick) begin
        task_idx_ff <= task_idx_ff + 1'b1;
      end
    end
  end

  // Delay starts with the sync pulse itself
  cms_pct_timer #(.CW(CW)) u_pdo_delay (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .start(sync_tx_ff),
    .period(sync_period_ff),
    .pct(output_pdo_delay_percent),
    .limit(sync_period_ff),
    .running(pdo_running),
    .fire(pdo_tx)
  );

  // Pulse lands a cycle after the limit, so reserve one more
  assign in_limit = (({1'b0, input_copy_duration} + 1'b1) >= {1'b0, task_period_ff}) ? '0
                  : task_period_ff - input_copy_duration - 1'b1;

  cms_pct_timer #(.CW(CW)) u_input_shift (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .start(tick),
    .period(task_period_ff),
    .pct(input_shift_percent),
    .limit(in_limit),
    .running(in_running),
    .fire(input_update)
  );

  assign resp_done = resp.valid || (wait_cnt_ff == TIMEOUT_LAST);
  assign resp_ok = resp.valid && resp.ok;

  // Network walk; absent nodes show as timeouts
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= CMS_ST_IDLE;
      mode_ff <= CMS_MODE_SCAN;
      phase_ff <= 1'b0;
      node_ff <= NODE_MIN;
      wait_cnt_ff <= '0;
      req_ff <= '0;
      busy_ff <= 1'b0;
      found_ff <= '0;
      mismatch_ff <= 1'b0;
      bitrate_fail_ff <= 1'b0;
    end else begin
      req_ff.valid <= 1'b0;
      unique case (state_ff)
        CMS_ST_IDLE: begin
          node_ff <= NODE_MIN;
          phase_ff <= 1'b0;
          if (cmd_evt.bus_reset) begin
            req_ff <= '{valid: 1'b1, op: CMS_OP_NMT_RESET, node: NODE_BROADCAST};
          end else if (cmd_evt.scan && config_mode) begin
            mode_ff <= CMS_MODE_SCAN;
            found_ff <= '0;
            busy_ff <= 1'b1;
            state_ff <= CMS_ST_ISSUE;
          end else if (cmd_evt.verify && config_mode) begin
            mode_ff <= CMS_MODE_VERIFY;
            mismatch_ff <= 1'b0;
            busy_ff <= 1'b1;
            state_ff <= CMS_ST_ISSUE;
          end else if (cmd_evt.bitrate_check) begin
            mode_ff <= CMS_MODE_BITRATE;
            bitrate_fail_ff <= 1'b0;
            busy_ff <= 1'b1;
            state_ff <= CMS_ST_ISSUE;
          end
        end
        CMS_ST_ISSUE: begin
          wait_cnt_ff <= '0;
          if (node_ff == own_node_address) begin
            state_ff <= CMS_ST_NEXT;
          end else begin
            req_ff.valid <= 1'b1;
            req_ff.node <= node_ff;
            if (mode_ff == CMS_MODE_BITRATE) begin
              req_ff.op <= CMS_OP_BITRATE;
            end else if (mode_ff == CMS_MODE_SCAN && !phase_ff) begin
              req_ff.op <= CMS_OP_PDO_CFG;
            end else begin
              req_ff.op <= CMS_OP_IDENTITY;
            end
            state_ff <= CMS_ST_WAIT;
          end
        end
        CMS_ST_WAIT: begin
          wait_cnt_ff <= wait_cnt_ff + 1'b1;
          if (resp_done) begin
            state_ff <= CMS_ST_NEXT;
            if (mode_ff == CMS_MODE_SCAN && !phase_ff && resp_ok) begin
              phase_ff <= 1'b1;
              state_ff <= CMS_ST_ISSUE;
            end else if (mode_ff == CMS_MODE_SCAN && phase_ff && resp_ok) begin
              found_ff <= found_ff + 1'b1;
            end else if (mode_ff == CMS_MODE_VERIFY && !resp_ok) begin
              mismatch_ff <= 1'b1;
            end else if (mode_ff == CMS_MODE_BITRATE && !resp_ok) begin
              bitrate_fail_ff <= 1'b1;
            end
          end
        end
        CMS_ST_NEXT: begin
          phase_ff <= 1'b0;
          if (node_ff == NODE_MAX) begin
            busy_ff <= 1'b0;
            state_ff <= CMS_ST_IDLE;
          end else begin
            node_ff <= node_ff + 1'b1;
            state_ff <= CMS_ST_ISSUE;
          end
        end
      endcase
    end
  end

  assign sync_tx = sync_tx_ff;
  assign heartbeat_cob_id = hb_cob_ff;
  assign node_addr_valid = addr_ok_ff;
  assign task_period = task_period_ff;
  assign sync_period = sync_period_ff;
  assign req = req_ff;
  assign busy = busy_ff;
  assign nodes_found = found_ff;
  assign mismatch = mismatch_ff;
  assign bitrate_fail = bitrate_fail_ff;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_tick_at_wrap;
    tick && (task_idx_ff >= ratio_eff - RATIO_MIN);
  endsequence

  sequence s_reset_cmd;
    (state_ff == CMS_ST_IDLE) && cmd_evt.bus_reset;
  endsequence

  a_heartbeat_id: assert property ($changed(own_node_address) |=>
    heartbeat_cob_id == (HB_COB_BASE | {4'h0, $past(own_node_address)}))
    else $error("heartbeat id not derived from node address");

  a_sync_on_wrap: assert property (s_tick_at_wrap |=> sync_tx && task_idx_ff == '0)
    else $error("sync missing at task count wrap");

  a_sync_only_wrap: assert property (sync_tx |-> $past(tick))
    else $error("sync without task tick");

  a_sync_period: assert property ((sync_prod[CW+7:CW] == '0) |=>
    sync_period == $past(sync_prod[CW-1:0]))
    else $error("sync period not task period times ratio");

  a_pdo_after_sync: assert property (sync_tx |=> ##[0:1] pdo_running)
    else $error("output delay timer not started by sync");

  a_update_in_window: assert property (tick |=> in_running)
    else $error("input update timer not started by tick");

  a_bus_reset_req: assert property (s_reset_cmd |=>
    req.valid && req.op == CMS_OP_NMT_RESET && req.node == NODE_BROADCAST)
    else $error("bus reset not broadcast");

  a_walk_config_only: assert property ((state_ff == CMS_ST_IDLE) && !config_mode
    && !cmd_evt.bitrate_check |=> state_ff == CMS_ST_IDLE)
    else $error("walk started outside configuration mode");

  a_skip_own_node: assert property (req.valid && req.op != CMS_OP_NMT_RESET
    |-> req.node != own_node_address)
    else $error("own node address probed");

  a_req_single: assert property (req.valid && req.op != CMS_OP_NMT_RESET
    |=> !req.valid)
    else $error("probe request longer than one cycle");
endmodule

// ---- verification/cms_slave_model.sv ----
// CAN slave nodes answering the scheduler's requests
`timescale 1ns/1ps
module cms_slave_model import cms_pkg::*; (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire cms_req_t req,
  input wire logic sync_tx,
  input wire logic [6:0] absent_node,
  input wire logic [6:0] bad_node,
  input wire logic [3:0] lat,
  output cms_resp_t resp,
  output logic slave_pdo
);
  logic [3:0] wait_ff;
  logic pend_ff;
  cms_req_t held_ff;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) slave_pdo <= 1'b0;
    else slave_pdo <= sync_tx;
  end
  // Broadcast and absent nodes stay silent; ok toggles while idle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pend_ff <= 1'b0;
      wait_ff <= 4'h0;
      held_ff <= '0;
      resp <= '0;
    end else if (req.valid && req.node != 7'h00 && req.node != absent_node) begin
      pend_ff <= 1'b1;
      wait_ff <= lat;
      held_ff <= req;
      resp <= {1'b0, ~resp.ok};
    end else if (pend_ff && wait_ff == 4'h0) begin
      pend_ff <= 1'b0;
      resp <= {1'b1, !(held_ff.node == bad_node && held_ff.op == CMS_OP_BITRATE)};
    end else begin
      wait_ff <= wait_ff - 4'h1;
      resp <= {1'b0, ~resp.ok};
    end
  end
endmodule

// ---- verification/canopen_master_sync_scheduler_bench.sv ----
// Bench for the sync scheduler with slave model
`timescale 1ns/1ps
module canopen_master_sync_scheduler_bench;
  import cms_pkg::*;
  typedef struct packed {logic [6:0] a; logic [10:0] cob; logic ok;} cms_row_t;
  logic ref_clk, resetn, tick, cfg, sync_tx, pdo_tx, in_upd, nav, busy, mism, brf, spdo;
  cms_cmd_t cmd;
  logic [6:0] own, absent, bad, found;
  logic [6:0] last = 7'h00;
  logic [6:0] rst_node = 7'h55;
  logic [7:0] ratio, ppct, ipct;
  logic [23:0] copy, tper, sper;
  logic [10:0] cob;
  cms_req_t req;
  cms_resp_t resp;
  int errors = 0;
  int n_tests = 0;
  int since = 0;
  int pdo_gap = 0;
  int in_gap = 0;
  int n_sync = 0;
  int n_req = 0;
  int s0;
  logic obad = 1'b0;
  logic burst = 1'b0;
  cms_row_t rows [4] = '{{7'h00, 11'h700, 1'b0}, {7'h01, 11'h701, 1'b1},
    {7'h7F, 11'h77F, 1'b1}, {7'h2A, 11'h72A, 1'b1}};
  cms_sched #(.CW(24), .RESP_TIMEOUT(8)) DUT (.ref_clk(ref_clk), .resetn(resetn),
    .task_tick_pin(tick), .cmd_pin(cmd), .config_mode(cfg), .own_node_address(own),
    .sync_ratio(ratio), .output_pdo_delay_percent(ppct), .input_shift_percent(ipct),
    .input_copy_duration(copy), .resp(resp), .sync_tx(sync_tx), .pdo_tx(pdo_tx),
    .input_update(in_upd), .heartbeat_cob_id(cob), .node_addr_valid(nav),
    .task_period(tper), .sync_period(sper), .req(req), .busy(busy),
    .nodes_found(found), .mismatch(mism), .bitrate_fail(brf));
  cms_slave_model slaves (.ref_clk(ref_clk), .resetn(resetn), .req(req),
    .sync_tx(sync_tx), .absent_node(absent), .bad_node(bad), .lat(4'h2),
    .resp(resp), .slave_pdo(spdo));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %0h want %0h", $time, m, got, exp);
    end
  endtask
  task automatic rng(input int got, input int lo, input int hi, input string m);
    n_tests++;
    if (got < lo || got > hi) begin
      errors++;
      $display("wrong value at %0t: %s got %0d", $time, m, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      tick <= 1'b1;
      cyc(20);
      tick <= 1'b0;
      cyc(20);
    end
  endtask
  // Pulse wide enough to pass the input filter, then wait out the walk
  task automatic run(input cms_cmd_t c);
    int k;
    cmd <= c;
    cyc(4);
    cmd <= '0;
    cyc(4);
    for (k = 0; k < 20000 && busy !== 1'b0; k++) cyc(1);
    chk(busy, 1'b0, "walk end");
  endtask
  task automatic summarize();
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    since <= sync_tx ? 0 : since + 1;
    if (sync_tx) n_sync <= n_sync + 1;
    if (pdo_tx) pdo_gap <= since;
    if (in_upd) in_gap <= since;
    if (req.valid) n_req <= n_req + 1;
    if (pdo_tx && spdo) burst <= 1'b1;
    if (!busy) last <= 7'h00;
    if (req.valid && req.op == CMS_OP_NMT_RESET) rst_node <= req.node;
    else if (req.valid) begin
      if (req.node == own || req.node < last) obad <= 1'b1;
      last <= req.node;
    end
  end
  initial begin
    cyc(40000);
    errors++;
    summarize();
  end
  initial begin
    {resetn, tick, cmd, cfg, ratio, ppct, ipct, copy} = '0;
    {absent, bad} = '0;
    own = 7'h7F;
    cyc(2);
    chk(cob, 11'h700, "reset cob");
    chk({sync_tx, busy, found}, '0, "reset outs");
    resetn <= 1'b1;
    foreach (rows[i]) begin
      own <= rows[i].a;
      cyc(3);
      chk({cob, nav}, {rows[i].cob, rows[i].ok}, "heartbeat");
    end
    own <= 7'h7F;
    ratio <= 8'h03;
    ppct <= 8'h28;
    ipct <= 8'h32;
    ticks(4);
    s0 = n_sync;
    ticks(9);
    chk(n_sync - s0, 3, "sync per 9 ticks");
    chk(sper, 24'h78, "sync period");
    chk(tper, 24'h28, "task period");
    rng(pdo_gap, 44, 52, "pdo delay");
    ratio <= 8'h00;
    ticks(3);
    s0 = n_sync;
    ticks(4);
    chk(n_sync - s0, 4, "ratio zero");
    rng(in_gap, 17, 23, "input shift");
    chk(burst, 1'b0, "pdo in sync burst");
    copy <= 24'h1E;
    ticks(3);
    rng(in_gap, 7, 9, "copy limit");
    s0 = n_req;
    run(4'b0100);
    chk(n_req - s0, 0, "scan refused");
    cfg <= 1'b1;
    absent <= 7'h05;
    bad <= 7'h09;
    run(4'b0100);
    chk(found, 7'h7D, "scan count");
    chk(obad, 1'b0, "walk order");
    run(4'b0010);
    chk(mism, 1'b1, "verify absent");
    absent <= 7'h00;
    run(4'b0010);
    chk(mism, 1'b0, "verify clean");
    run(4'b0001);
    chk(brf, 1'b1, "bitrate refused");
    run(4'b1000);
    chk(rst_node, 7'h00, "bus reset");
    resetn <= 1'b0;
    cyc(2);
    chk({cob, found, brf}, {11'h700, 8'h00}, "mid reset");
    resetn <= 1'b1;
    cyc(3);
    chk({cob, nav, sync_tx, busy}, {11'h77F, 1'b1, 2'b00}, "after reset");
    summarize();
  end
endmodule
